//--- design/tpw_pin_sync.sv
// two-flop synchroniser and edge finder for the trigger pin
`timescale 1ns/100ps
`default_nettype none
module tpw_pin_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // raw pin and edge choice
  input wire logic pin_raw,
  input wire logic rise_sel,
  // synchronised results
  output logic pin_level,
  output logic pin_edge
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } tpw_sync_state_t;

  tpw_sync_state_t s_q;
  tpw_sync_state_t s_d;

  // meta feeds only sync; edges use sync against prev
  always_comb
  begin
    s_d.meta = pin_raw;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign pin_level = s_q.sync;
  assign pin_edge = rise_sel ? (s_q.sync & ~s_q.prev)
                             : (~s_q.sync & s_q.prev);

endmodule : tpw_pin_sync
`default_nettype wire

//--- design/tpw_pkg.sv
// constants, field layout and types of the timer pwm block
// Function
// - counter counts down; selectable 16-bit modulator or 8-bit modulator with prescaler
// - at each pulse rising edge counter reloads from reload register, keeps counting
// - trigger events during counting are ignored, no reload or restart
// - 16-bit: high time is n count clock periods
// - 16-bit: period fixed at 2^16-1 count clock periods
// - 8-bit: high time n*(m+1) periods, n upper byte, m lower byte
// - 8-bit: period (2^8-1)*(m+1) periods, lower byte acts as prescaler
// - counting starts on trigger pin, other timer overflow, or start flag
// - clearing the start flag stops counting
// - interrupt request raised at each falling edge of the pulse while counting, not at the fall caused by a stop
// - trigger pin works as general port or as external trigger input
// - reading the timer value register returns a fixed fill, not the count
// - write while stopped updates reload register and counter together
// - write while counting updates reload only; counter takes it at next reload
package tpw_pkg;

  // bus geometry and register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_VALUE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CLEAR = 8'h0c;
  localparam logic [7:0] OFS_IRQ_EN = 8'h10;
  localparam logic [7:0] OFS_PORT = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;

  // control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_MODE8_BIT = 1;
  localparam int CTRL_CKS_LSB = 2;
  localparam int CTRL_TSEL_LSB = 4;
  localparam int CTRL_PORT_BIT = 6;
  localparam int CTRL_RISE_BIT = 7;

  // port register fields, status bits
  localparam int PORT_OUT_BIT = 0;
  localparam int PORT_DIR_BIT = 1;
  localparam int PORT_PIN_BIT = 2;
  localparam int ST_FALL_BIT = 0;
  localparam int ST_RISE_BIT = 1;

  // reset values and the fill returned for the value register
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [31:0] VALUE_READ_FILL = 32'h0000_0000;

  // last period unit index: period is 2^16-1 or 2^8-1 units
  localparam logic [15:0] PERIOD16_LAST = 16'hfffe;
  localparam logic [15:0] PERIOD8_LAST = 16'h00fe;

  // prescaler divide ratios
  localparam int DIV_EIGHT = 8;
  localparam int DIV_THIRTY_TWO = 32;

  typedef enum logic [1:0] {
    CKS_UNDIV = 2'b00,
    CKS_DIV8 = 2'b01,
    CKS_DIV32 = 2'b10,
    CKS_OFF = 2'b11
  } tpw_cks_t;

  typedef enum logic [1:0] {
    TS_SOFT = 2'b00,
    TS_PIN = 2'b01,
    TS_OVF = 2'b10,
    TS_RSVD = 2'b11
  } tpw_tsel_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_RUN = 2'b10
  } tpw_state_t;

endpackage : tpw_pkg

//--- design/tpw_prescale.sv
// prescaler making the selected count clock tick
`timescale 1ns/100ps
`default_nettype none
module tpw_prescale
  import tpw_pkg::*;
#(
  parameter int DIV_A = DIV_EIGHT,
  parameter int DIV_B = DIV_THIRTY_TWO
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // tick towards the counter
  tpw_tick_if.src tick_bus
);

  localparam int CW = $clog2(DIV_B);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } tpw_pre_state_t;

  tpw_pre_state_t s_q;
  tpw_pre_state_t s_d;

  // both ratios must be powers of two and the first the smaller
  if (DIV_A < 2 || DIV_B <= DIV_A || (DIV_A & (DIV_A - 1)) != 0 ||
      (DIV_B & (DIV_B - 1)) != 0)
  begin : g_bad_div
    $error("tpw_prescale: unusable divide ratios");
  end

  // free running divider; tick is one cycle wide
  always_comb
  begin
    s_d = s_q;
    s_d.cnt = s_q.cnt + 1'b1;
    case (tick_bus.cks)
      CKS_UNDIV: s_d.tick = 1'b1;
      CKS_DIV8: s_d.tick = (s_q.cnt[$clog2(DIV_A)-1:0] == '1);
      CKS_DIV32: s_d.tick = (s_q.cnt == '1);
      default: s_d.tick = 1'b0; // inhibited selection never ticks
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick_bus.tick = s_q.tick;

endmodule : tpw_prescale
`default_nettype wire

//--- design/tpw_tick_if.sv
// count clock selection and tick between top and prescaler
`timescale 1ns/100ps
`default_nettype none
interface tpw_tick_if;
  import tpw_pkg::*;
  tpw_cks_t cks;
  logic tick;
  modport src (input cks, output tick);
  modport snk (output cks, input tick);
endinterface : tpw_tick_if
`default_nettype wire

//--- design/tpw_timer_pwm.sv
// timer channel in pulse width modulation mode with avalon-mm registers
`timescale 1ns/100ps
`default_nettype none
module tpw_timer_pwm
  import tpw_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // overflow pulse of another timer, same clock
  input wire logic ovf_in,
  // trigger pin, two-way
  input wire logic timer_trigger_pin_i,
  output logic timer_trigger_pin_o,
  output logic timer_trigger_pin_oe,
  // pulse output and interrupt
  output logic pulse_output_pin,
  output logic irq
);

  typedef struct packed {
    tpw_state_t st;
    logic start;
    logic mode8;
    tpw_cks_t cks;
    tpw_tsel_t tsel;
    logic port_mode;
    logic trig_rise;
    logic [15:0] reload;
    logic [15:0] hi;
    logic [7:0] pre;
    logic [7:0] div;
    logic [15:0] per;
    logic pulse;
    logic [1:0] status;
    logic [1:0] irq_en;
    logic pin_out;
    logic pin_dir;
    logic ack;
    logic [31:0] rdata;
  } tpw_top_state_t;

  tpw_top_state_t s_q;
  tpw_top_state_t s_d;

  logic pin_level;
  logic pin_edge;
  logic req;
  logic take;
  logic wr_go;
  logic trig_ev;
  logic tick;
  logic unit;
  logic [31:0] wmask;
  logic [31:0] clr;
  logic [1:0] ev;

  tpw_tick_if tick_if ();

  // byte enable merge of a register word
  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] be
  );
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    be_merge = (old_v & ~m) | (new_v & m);
  endfunction : be_merge

  // high-time count taken from a timer value
  function automatic logic [15:0] high_of(
    input logic [15:0] val,
    input logic mode8
  );
    high_of = mode8 ? {8'h00, val[15:8]} : val;
  endfunction : high_of

  // last period unit index for the active width
  function automatic logic [15:0] last_of(input logic mode8);
    last_of = mode8 ? PERIOD8_LAST : PERIOD16_LAST;
  endfunction : last_of

  // control word as seen by software
  function automatic logic [31:0] ctrl_word(input tpw_top_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[CTRL_START_BIT] = s.start;
    w[CTRL_MODE8_BIT] = s.mode8;
    w[CTRL_CKS_LSB +: 2] = s.cks;
    w[CTRL_TSEL_LSB +: 2] = s.tsel;
    w[CTRL_PORT_BIT] = s.port_mode;
    w[CTRL_RISE_BIT] = s.trig_rise;
    ctrl_word = w;
  endfunction : ctrl_word

  // count clock source
  tpw_prescale #(
    .DIV_A(DIV_EIGHT),
    .DIV_B(DIV_THIRTY_TWO)
  ) u_prescale (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .tick_bus(tick_if)
  );

  assign tick_if.cks = s_q.cks;
  assign tick = tick_if.tick;

  // trigger pin is asynchronous to clk_sys
  tpw_pin_sync u_pin_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin_raw(timer_trigger_pin_i),
    .rise_sel(s_q.trig_rise),
    .pin_level(pin_level),
    .pin_edge(pin_edge)
  );

  // bus handshake: one wait cycle, write lands when waitrequest is low
  assign req = avs_read | avs_write;
  assign take = req & ~s_q.ack;
  assign wr_go = avs_write & s_q.ack;
  assign avs_waitrequest = req & ~s_q.ack;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // pin triggers only when not used as a port
  always_comb
  begin
    case (s_q.tsel)
      TS_PIN: trig_ev = pin_edge & ~s_q.port_mode;
      TS_OVF: trig_ev = ovf_in;
      default: trig_ev = 1'b0;
    endcase
  end

  // in 8-bit mode a unit is m+1 count ticks
  assign unit = tick & (~s_q.mode8 | (s_q.pre == 8'h00));

  always_comb
  begin
    s_d = s_q;
    s_d.ack = take;
    clr = 32'h0000_0000;
    ev = 2'b00;

    // read data captured on the first cycle of the request
    if (take && avs_read)
    begin
      case (avs_address)
        OFS_CTRL: s_d.rdata = ctrl_word(s_q);
        OFS_VALUE: s_d.rdata = VALUE_READ_FILL;
        OFS_STATUS: s_d.rdata = {30'h0, s_q.status};
        OFS_IRQ_EN: s_d.rdata = {30'h0, s_q.irq_en};
        OFS_PORT: s_d.rdata = {29'h0, pin_level, s_q.pin_dir, s_q.pin_out};
        OFS_STATE: s_d.rdata = {27'h0, s_q.pulse, s_q.mode8, 1'b0, s_q.st};
        default: s_d.rdata = 32'h0000_0000; // unmapped and write-only
      endcase
    end

    // register writes
    if (wr_go)
    begin
      case (avs_address)
        OFS_CTRL:
        begin
          if (avs_byteenable[0])
          begin
            s_d.start = avs_writedata[CTRL_START_BIT];
            s_d.mode8 = avs_writedata[CTRL_MODE8_BIT];
            s_d.cks = tpw_cks_t'(avs_writedata[CTRL_CKS_LSB +: 2]);
            s_d.tsel = tpw_tsel_t'(avs_writedata[CTRL_TSEL_LSB +: 2]);
            s_d.port_mode = avs_writedata[CTRL_PORT_BIT];
            s_d.trig_rise = avs_writedata[CTRL_RISE_BIT];
          end
        end
        OFS_VALUE:
        begin
          s_d.reload = 16'(be_merge({16'h0, s_q.reload}, avs_writedata,
                                    avs_byteenable));
          // stopped: counter follows the write at once
          // counting: only the reload register changes
          if (s_q.st != ST_RUN)
          begin
            s_d.hi = high_of(s_d.reload, s_d.mode8);
            s_d.div = s_d.reload[7:0];
            s_d.pre = s_d.reload[7:0];
          end
        end
        OFS_CLEAR: clr = avs_writedata & wmask;
        OFS_IRQ_EN: s_d.irq_en = avs_byteenable[0] ? avs_writedata[1:0]
                                                   : s_q.irq_en;
        OFS_PORT:
        begin
          if (avs_byteenable[0])
          begin
            s_d.pin_out = avs_writedata[PORT_OUT_BIT];
            s_d.pin_dir = avs_writedata[PORT_DIR_BIT];
          end
        end
        default: ; // unmapped writes are dropped
      endcase
    end

    // counter sequencing
    if (!s_d.start)
    begin
      // clearing the flag stops the counter
      s_d.st = ST_IDLE;
    end
    else
    begin
      case (s_q.st)
        ST_IDLE:
        begin
          if (s_d.tsel == TS_SOFT || s_d.tsel == TS_RSVD)
          begin
            s_d.st = ST_RUN;
            s_d.per = last_of(s_d.mode8);
          end
          else
            s_d.st = ST_ARMED;
        end
        ST_ARMED:
        begin
          if (trig_ev)
          begin
            s_d.st = ST_RUN;
            s_d.per = last_of(s_q.mode8);
          end
        end
        ST_RUN:
        begin
          // trig_ev is not looked at while counting
          // down counting on the selected count clock
          if (tick && s_q.mode8)
            s_d.pre = (s_q.pre == 8'h00) ? s_q.div : s_q.pre - 8'h01;
          if (unit)
          begin
            if (s_q.per == 16'h0000)
            begin
              // reload at the pulse rising edge and keep going
              // period closes after the fixed unit count
              s_d.per = last_of(s_q.mode8);
              s_d.hi = high_of(s_q.reload, s_q.mode8);
              s_d.div = s_q.reload[7:0];
              s_d.pre = s_q.reload[7:0];
            end
            else
            begin
              s_d.per = s_q.per - 16'h0001;
              // high time ends after n units
              if (s_q.hi != 16'h0000)
                s_d.hi = s_q.hi - 16'h0001;
            end
          end
        end
        default: s_d.st = ST_IDLE;
      endcase
    end

    // output high from period start while high count remains
    s_d.pulse = (s_d.st == ST_RUN) && (s_d.hi != 16'h0000);

    // falling edge while running raises the request
    ev[ST_FALL_BIT] = s_q.pulse & ~s_d.pulse & (s_d.st == ST_RUN);
    // any rise is a period start, the one at start included
    ev[ST_RISE_BIT] = ~s_q.pulse & s_d.pulse;

    // sticky status: a new event beats a clear in the same cycle
    s_d.status = (s_q.status & ~clr[1:0]) | ev;
  end

  // state register
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.cks <= CKS_UNDIV;
      s_q.tsel <= TS_SOFT;
      s_q.reload <= RELOAD_RST;
    end
    else
      s_q <= s_d;
  end

  // outputs
  assign avs_readdata = s_q.rdata;
  assign pulse_output_pin = s_q.pulse;
  assign irq = |(s_q.status & s_q.irq_en);
  // pin driven only as an output port
  assign timer_trigger_pin_o = s_q.pin_out;
  assign timer_trigger_pin_oe = s_q.port_mode & s_q.pin_dir;

endmodule : tpw_timer_pwm
`default_nettype wire

//--- verif/test_tpw_timer_pwm.sv
// self-checking bench of the timer pwm block
`timescale 1ns/100ps
`default_nettype none
bind tpw_timer_pwm tpw_timer_pwm_assertions chk_u (.clk_sys, .arst_n,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .ovf_in, .timer_trigger_pin_i,
  .timer_trigger_pin_o, .timer_trigger_pin_oe, .pulse_output_pin, .irq);
module test_tpw_timer_pwm;
  import tpw_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, hi_len, per_len, rises;
  logic avs_waitrequest, ovf_in, timer_trigger_pin_i, timer_trigger_pin_o;
  logic timer_trigger_pin_oe, pulse_output_pin, irq;
  logic trig_lvl = 1'b0;
  logic ovf_req = 1'b0;
  int fails = 0;
  int checked = 0;

  // 10 mhz system clock
  always #50 clk_sys = ~clk_sys;

  tpw_timer_pwm dut_u (.clk_sys, .arst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .ovf_in, .timer_trigger_pin_i, .timer_trigger_pin_o,
    .timer_trigger_pin_oe, .pulse_output_pin, .irq);
  tpw_partner partner_u (.clk_sys, .arst_n, .trig_lvl, .ovf_req,
    .pin_o(timer_trigger_pin_o), .pin_oe(timer_trigger_pin_oe),
    .pulse(pulse_output_pin), .pin_i(timer_trigger_pin_i), .ovf_in,
    .hi_len, .per_len, .rises);

  task automatic chk(input string nm, input logic [31:0] exp, got);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one transfer; request held until an edge sees waitrequest low
  task automatic bus(input logic rd, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    do
      @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
    input string nm);
    logic [31:0] q;
    bus(1'b1, a, 32'h0, q);
    chk(nm, e, q);
  endtask : rdc

  task automatic wait_rise(input int k);
    int r0;
    r0 = int'(rises);
    for (int i = 0; i < 150000 && int'(rises) < r0 + k; i++)
      @(negedge clk_sys);
    chk("rise count", 32'(r0 + k), rises);
  endtask : wait_rise

  task automatic wait_low;
    for (int i = 0; i < 150000 && pulse_output_pin !== 1'b0; i++)
      @(negedge clk_sys);
    // the load latches the width one edge after the fall
    repeat (2) @(negedge clk_sys);
  endtask : wait_low

  task automatic t_regs;
    rdc(OFS_CTRL, 32'h0, "ctrl reset");
    wr(OFS_VALUE, 32'h1234);
    rdc(OFS_VALUE, VALUE_READ_FILL, "value read");
    wr(8'h40, 32'hffff_ffff);
    rdc(8'h40, 32'h0, "unmapped read");
    wr(OFS_CTRL, 32'h40);
    wr(OFS_PORT, 32'h3);
    repeat (4) @(posedge clk_sys);
    rdc(OFS_PORT, 32'h7, "port high");
    wr(OFS_PORT, 32'h2);
    repeat (4) @(posedge clk_sys);
    rdc(OFS_PORT, 32'h2, "port low");
    wr(OFS_CTRL, 32'h0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_pwm16;
    wr(OFS_VALUE, 32'h5);
    wr(OFS_CTRL, 32'h1);
    wait_rise(1);
    wait_low;
    chk("high 16", 32'h5, hi_len);
    rdc(OFS_STATUS, 32'h3, "status");
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(OFS_IRQ_EN, 32'h1);
    @(negedge clk_sys);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(OFS_CLEAR, 32'h3);
    @(negedge clk_sys);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(OFS_VALUE, 32'h9);
    wait_rise(1);
    chk("period 16", 32'hffff, per_len);
    wait_low;
    chk("high reloaded", 32'h9, hi_len);
    wr(OFS_CTRL, 32'h0);
    repeat (2) @(negedge clk_sys);
    chk("stopped low", 32'h0, {31'h0, pulse_output_pin});
    $display("test pwm16 done");
  endtask : t_pwm16

  task automatic t_pwm8;
    int nn[3] = '{4, 4, 3};
    int mm[3] = '{2, 0, 0};
    int dv[3] = '{1, DIV_EIGHT, DIV_THIRTY_TWO};
    for (int j = 0; j < 3; j++)
    begin
      // mode set while stopped, so the value splits into n and m
      wr(OFS_CTRL, 32'(j * 4 + 2));
      wr(OFS_VALUE, 32'(nn[j] * 256 + mm[j]));
      wr(OFS_CTRL, 32'(j * 4 + 3));
      // first period has an arbitrary tick phase; measure the next
      wait_rise(3);
      wait_low;
      chk("period 8", 32'(255 * (mm[j] + 1) * dv[j]), per_len);
      chk("high 8", 32'(nn[j] * (mm[j] + 1) * dv[j]), hi_len);
    end
    wr(OFS_CTRL, 32'h0);
    $display("test pwm8 done");
  endtask : t_pwm8

  task automatic t_trig;
    int r0;
    wr(OFS_VALUE, 32'h2);
    r0 = int'(rises);
    wr(OFS_CTRL, 32'h91);
    repeat (8) @(posedge clk_sys);
    chk("armed by pin", 32'(r0), rises);
    trig_lvl <= 1'b1;
    wait_rise(1);
    repeat (3) @(posedge clk_sys);
    trig_lvl <= 1'b0;
    repeat (3) @(posedge clk_sys);
    trig_lvl <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk("pin ignored", 32'(r0 + 1), rises);
    chk("high by pin", 32'h2, hi_len);
    wr(OFS_CTRL, 32'h0);
    // counter ran down to zero, so load it again while stopped
    wr(OFS_VALUE, 32'h2);
    wr(OFS_CTRL, 32'h21);
    repeat (8) @(posedge clk_sys);
    chk("armed by ovf", 32'(r0 + 1), rises);
    ovf_req <= ~ovf_req;
    wait_rise(1);
    // let the pulse fall first, so a restart would show as a rise
    repeat (4) @(posedge clk_sys);
    ovf_req <= ~ovf_req;
    repeat (20) @(posedge clk_sys);
    chk("ovf ignored", 32'(r0 + 2), rises);
    wr(OFS_CTRL, 32'h0);
    $display("test trigger done");
  endtask : t_trig

  task automatic close_out;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // main sequence after six reset cycles
  initial
  begin
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_regs;
    t_pwm16;
    t_pwm8;
    t_trig;
    close_out;
  end

  // run needs about 88k cycles, mostly one long 16-bit period
  initial
  begin
    repeat (96000) @(posedge clk_sys);
    fails++;
    $display("[FAIL] watchdog expected end seen hang");
    close_out;
  end
endmodule : test_tpw_timer_pwm
`default_nettype wire

//--- verif/tpw_partner.sv
// trigger source and measuring load on the pulse output
`timescale 1ns/100ps
`default_nettype none
module tpw_partner (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // requests from the bench
  input wire logic trig_lvl,
  input wire logic ovf_req,
  // timer pins
  input wire logic pin_o,
  input wire logic pin_oe,
  input wire logic pulse,
  output logic pin_i,
  output logic ovf_in,
  // pulse train measurements
  output logic [31:0] hi_len,
  output logic [31:0] per_len,
  output logic [31:0] rises
);
  logic rq_q, pq_q;
  logic [31:0] hc_q, pc_q;
  // timer drive wins over the source
  assign pin_i = pin_oe ? pin_o : trig_lvl;
  // one overflow cycle per toggle; widths counted in clocks
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      {rq_q, pq_q, ovf_in, hc_q, pc_q, hi_len, per_len, rises} <= '0;
    else
    begin
      rq_q <= ovf_req;
      ovf_in <= ovf_req ^ rq_q;
      pq_q <= pulse;
      hc_q <= pulse ? hc_q + 32'h1 : 32'h0;
      pc_q <= (pulse && !pq_q) ? 32'h0 : pc_q + 32'h1;
      if (pulse && !pq_q)
        per_len <= pc_q + 32'h1;
      if (pulse && !pq_q)
        rises <= rises + 32'h1;
      if (!pulse && pq_q)
        hi_len <= hc_q;
    end
  end
endmodule : tpw_partner
`default_nettype wire

//--- verif/tpw_timer_pwm_assertions.sv
// port checker of the timer pwm block
`timescale 1ns/100ps
`default_nettype none
module tpw_timer_pwm_assertions
  import tpw_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // pins
  input wire logic ovf_in,
  input wire logic timer_trigger_pin_i,
  input wire logic timer_trigger_pin_o,
  input wire logic timer_trigger_pin_oe,
  input wire logic pulse_output_pin,
  input wire logic irq
);
  logic [7:0] ctl_q, prt_q, ien_q;
  logic [15:0] nv_q, cur_q;
  logic [16:0] hc_q, pc_q;
  logic pq_q, run_q;
  wire logic wr_ok = avs_write && !avs_waitrequest;
  wire logic rise = pulse_output_pin && !pq_q;
  // expected widths from the value in use this period
  wire logic [16:0] hi_exp = ctl_q[1] ?
    17'(cur_q[15:8]) * (17'(cur_q[7:0]) + 17'h1) : {1'b0, cur_q};
  wire logic [16:0] per_exp = ctl_q[1] ?
    17'hff * (17'(cur_q[7:0]) + 17'h1) : 17'hffff;

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // shadow of software writes; byte lanes assumed whole
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      {ctl_q, prt_q, ien_q, nv_q, cur_q, hc_q, pc_q, pq_q, run_q} <= '0;
    else
    begin
      if (wr_ok && avs_address == OFS_CTRL)
        ctl_q <= avs_writedata[7:0];
      if (wr_ok && avs_address == OFS_PORT)
        prt_q <= avs_writedata[7:0];
      if (wr_ok && avs_address == OFS_IRQ_EN)
        ien_q <= avs_writedata[7:0];
      if (wr_ok && avs_address == OFS_VALUE)
        nv_q <= avs_writedata[15:0];
      if (rise)
        cur_q <= nv_q;
      pq_q <= pulse_output_pin;
      hc_q <= pulse_output_pin ? hc_q + 17'h1 : 17'h0;
      pc_q <= rise ? 17'h1 : pc_q + 17'h1;
      // rise at a start closes no period, so skip it
      run_q <= ctl_q[0] && (run_q || rise);
    end
  end

  a_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest longer than one cycle");
  a_wait_idle: assert property (
    !avs_read && !avs_write |-> !avs_waitrequest)
    else $error("waitrequest without a request");
  a_value_fill: assert property (
    avs_read && !avs_waitrequest && avs_address == OFS_VALUE
    |-> avs_readdata == VALUE_READ_FILL)
    else $error("value register read shows a count");
  a_unmapped_zero: assert property (
    avs_read && !avs_waitrequest && avs_address >= 8'h1c
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_high_width: assert property (
    $fell(pulse_output_pin) && ctl_q[0] && ctl_q[3:2] == 2'b00
    |-> hc_q == hi_exp)
    else $error("pulse high time wrong");
  a_period_len: assert property (
    rise && run_q && ctl_q[3:2] == 2'b00 |-> pc_q == per_exp)
    else $error("pulse period wrong");
  a_stop_low: assert property (
    !ctl_q[0] && !$past(ctl_q[0]) |-> !pulse_output_pin)
    else $error("pulse high while stopped");
  a_fall_irq: assert property (
    $fell(pulse_output_pin) && ctl_q[0] && ien_q[0] |-> ##[0:2] irq)
    else $error("no interrupt after pulse fall");
  a_port_pins: assert property (
    timer_trigger_pin_oe == (ctl_q[6] && prt_q[1])
    && timer_trigger_pin_o == prt_q[0])
    else $error("trigger pin drive wrong");
endmodule : tpw_timer_pwm_assertions
`default_nettype wire
